// ### hdl/sfp_pkg.sv
package sfp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_W30 = 8'h30;
  localparam logic [7:0] ADDR_W34 = 8'h34;
  localparam logic [7:0] ADDR_W38 = 8'h38;
  localparam logic [7:0] ADDR_W3C = 8'h3c;
  localparam logic [7:0] ADDR_W40 = 8'h40;
  localparam logic [7:0] ADDR_W44 = 8'h44;
  localparam logic [7:0] ADDR_W48 = 8'h48;
  localparam logic [7:0] ADDR_W4C = 8'h4c;
  localparam logic [7:0] ADDR_W50 = 8'h50;
  localparam logic [7:0] ADDR_W54 = 8'h54;
  localparam logic [7:0] ADDR_CTRL = 8'h80;
  localparam logic [7:0] ADDR_STAT = 8'h84;
  localparam logic [7:0] ADDR_HDR = 8'h88;

  // ----------------------------------------------------------------
  // Table content
  // ----------------------------------------------------------------
  localparam logic [7:0] B30 = 8'he5;
  localparam logic [7:0] B31_ERASE4K_OP = 8'h20;
  localparam logic [7:0] B32 = 8'hfb;
  localparam logic [7:0] B33 = 8'hff;
  localparam logic [31:0] DENSITY = 32'h1fffffff;
  localparam logic [4:0] QIO_WAIT = 5'h04;
  localparam logic [2:0] QIO_MODE = 3'h2;
  localparam logic [7:0] QIO_OP = 8'heb;
  localparam logic [4:0] QO_WAIT = 5'h08;
  localparam logic [2:0] QO_MODE = 3'h0;
  localparam logic [7:0] QO_OP = 8'h6b;
  localparam logic [4:0] DO_WAIT = 5'h08;
  localparam logic [2:0] DO_MODE = 3'h0;
  localparam logic [7:0] DO_OP = 8'h3b;
  localparam logic [4:0] DIO_WAIT = 5'h00;
  localparam logic [2:0] DIO_MODE = 3'h4;
  localparam logic [7:0] DIO_OP = 8'hbb;
  localparam logic [7:0] B40 = 8'hfe;
  localparam logic [23:0] B41_43 = 24'hffffff;
  localparam logic [15:0] B44_45 = 16'hffff;
  localparam logic [7:0] B46 = 8'h00;
  localparam logic [7:0] B47 = 8'hff;
  localparam logic [15:0] B48_49 = 16'hffff;
  localparam logic [4:0] QPI_WAIT = 5'h04;
  localparam logic [2:0] QPI_MODE = 3'h2;
  localparam logic [7:0] QPI_OP = 8'heb;
  localparam logic [7:0] ER1_SIZE = 8'h0c;
  localparam logic [7:0] ER1_OP = 8'h20;
  localparam logic [7:0] ER2_SIZE = 8'h0f;
  localparam logic [7:0] ER2_OP = 8'h52;
  localparam logic [7:0] ER64_SIZE = 8'h10;
  localparam logic [7:0] ER256_SIZE = 8'h12;
  localparam logic [7:0] ER_BLK_OP = 8'hd8;
  localparam logic [7:0] ER_NONE_SIZE = 8'h00;
  localparam logic [7:0] ER_NONE_OP = 8'hff;
  localparam logic [3:0] ET_MULT = 4'h2;
  localparam logic [4:0] ET1_CNT = 5'h06;
  localparam logic [4:0] ET2_CNT = 5'h08;
  localparam logic [4:0] ET3_CNT = 5'h0a;
  localparam logic [4:0] ET4_CNT = 5'h05;
  localparam logic [4:0] ET_NONE_CNT = 5'h00;
  localparam logic [1:0] ET_UNIT = 2'h1;
  localparam logic [1:0] ET_NONE_UNIT = 2'h0;
  localparam logic [7:0] HDR_PTR = 8'h30;
  localparam logic [7:0] HDR_LEN = 8'h10;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### hdl/sfp_rom.sv
module sfp_rom #(
  parameter bit LARGE_BLOCK = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  // ----------------------------------------------------------------
  // Table words
  // ----------------------------------------------------------------
  wire logic [31:0] w30;
  wire logic [31:0] w34;
  wire logic [31:0] w38;
  wire logic [31:0] w3c;
  wire logic [31:0] w40;
  wire logic [31:0] w44;
  wire logic [31:0] w48;
  wire logic [31:0] w4c;
  wire logic [31:0] w50;
  wire logic [31:0] w54;
  wire logic [31:0] w_hdr;
  wire logic [15:0] er3;
  wire logic [15:0] er4;
  wire logic [6:0] et3;
  wire logic [6:0] et4;

  assign w30 = {sfp_pkg::B33, sfp_pkg::B32, sfp_pkg::B31_ERASE4K_OP,
                sfp_pkg::B30};
  assign w34 = sfp_pkg::DENSITY;
  assign w38 = {sfp_pkg::QO_OP, sfp_pkg::QO_MODE, sfp_pkg::QO_WAIT,
                sfp_pkg::QIO_OP, sfp_pkg::QIO_MODE,
                sfp_pkg::QIO_WAIT};
  assign w3c = {sfp_pkg::DIO_OP, sfp_pkg::DIO_MODE, sfp_pkg::DIO_WAIT,
                sfp_pkg::DO_OP, sfp_pkg::DO_MODE,
                sfp_pkg::DO_WAIT};
  assign w40 = {sfp_pkg::B41_43, sfp_pkg::B40};
  assign w44 = {sfp_pkg::B47, sfp_pkg::B46, sfp_pkg::B44_45};
  assign w48 = {sfp_pkg::QPI_OP, sfp_pkg::QPI_MODE, sfp_pkg::QPI_WAIT,
                sfp_pkg::B48_49};
  assign w4c = {sfp_pkg::ER2_OP, sfp_pkg::ER2_SIZE, sfp_pkg::ER1_OP,
                sfp_pkg::ER1_SIZE};
  assign er3 = LARGE_BLOCK ? {sfp_pkg::ER_NONE_OP, sfp_pkg::ER_NONE_SIZE}
             : {sfp_pkg::ER_BLK_OP, sfp_pkg::ER64_SIZE};
  assign er4 = LARGE_BLOCK ? {sfp_pkg::ER_BLK_OP, sfp_pkg::ER256_SIZE}
             : {sfp_pkg::ER_NONE_OP, sfp_pkg::ER_NONE_SIZE};
  assign w50 = {er4, er3};
  assign et3 = LARGE_BLOCK ? {sfp_pkg::ET_NONE_UNIT, sfp_pkg::ET_NONE_CNT}
             : {sfp_pkg::ET_UNIT, sfp_pkg::ET3_CNT};
  assign et4 = LARGE_BLOCK ? {sfp_pkg::ET_UNIT, sfp_pkg::ET4_CNT}
             : {sfp_pkg::ET_NONE_UNIT, sfp_pkg::ET_NONE_CNT};
  assign w54 = {et4, et3, sfp_pkg::ET_UNIT, sfp_pkg::ET2_CNT,
                sfp_pkg::ET_UNIT, sfp_pkg::ET1_CNT,
                sfp_pkg::ET_MULT};
  assign w_hdr = {16'h0000, sfp_pkg::HDR_LEN, sfp_pkg::HDR_PTR};

  // ----------------------------------------------------------------
  // Control register and status read counter
  // ----------------------------------------------------------------
  logic [31:0] scratch_q;
  logic [31:0] scratch_d;
  logic [15:0] rd_count_q;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  wire logic wr_go;
  wire logic wr_ok;

  assign s_axi_awready_o = ce_i && !aw_full_q && !bvalid_q;
  assign s_axi_wready_o = ce_i && !w_full_q && !bvalid_q;
  assign wr_go = aw_full_q && w_full_q && !bvalid_q;
  assign wr_ok = (awaddr_q == sfp_pkg::ADDR_CTRL);
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;

  always_comb begin
    scratch_d = scratch_q;
    for (int i = 0; i < 4; i++) begin
      if (wstrb_q[i]) begin
        scratch_d[i*8 +: 8] = wdata_q[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= sfp_pkg::RESP_OKAY;
      scratch_q <= 32'h00000000;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? sfp_pkg::RESP_OKAY : sfp_pkg::RESP_SLVERR;
        if (wr_ok) begin
          scratch_q <= scratch_d;
        end
      end else if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_word;
  logic rd_hit;

  assign s_axi_arready_o = ce_i && !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  always_comb begin
    rd_hit = 1'b1;
    if (s_axi_araddr_i == sfp_pkg::ADDR_W30) begin
      rd_word = w30;
    end else if (s_axi_araddr_i == sfp_pkg::ADDR_W34) begin
      rd_word = w34;
    end else if (s_axi_araddr_i == sfp_pkg::ADDR_W38) begin
      rd_word = w38;
    end else if (s_axi_araddr_i == sfp_pkg::ADDR_W3C) begin
      rd_word = w3c;
    end else if (s_axi_araddr_i == sfp_pkg::ADDR_W40) begin
      rd_word = w40;
    end else if (s_axi_araddr_i == sfp_pkg::ADDR_W44) begin
      rd_word = w44;
    end else if (s_axi_araddr_i == sfp_pkg::ADDR_W48) begin
      rd_word = w48;
    end else if (s_axi_araddr_i == sfp_pkg::ADDR_W4C) begin
      rd_word = w4c;
    end else if (s_axi_araddr_i == sfp_pkg::ADDR_W50) begin
      rd_word = w50;
    end else if (s_axi_araddr_i == sfp_pkg::ADDR_W54) begin
      rd_word = w54;
    end else if (s_axi_araddr_i == sfp_pkg::ADDR_CTRL) begin
      rd_word = scratch_q;
    end else if (s_axi_araddr_i == sfp_pkg::ADDR_STAT) begin
      rd_word = {15'h0000, LARGE_BLOCK, rd_count_q};
    end else if (s_axi_araddr_i == sfp_pkg::ADDR_HDR) begin
      rd_word = w_hdr;
    end else begin
      rd_word = 32'h00000000;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= sfp_pkg::RESP_OKAY;
      rd_count_q <= 16'h0000;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? sfp_pkg::RESP_OKAY : sfp_pkg::RESP_SLVERR;
        rd_count_q <= rd_count_q + 16'h0001;
      end else if (rvalid_q && s_axi_rready_i) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule

// ### tb/sfp_chk_assertions.sv
module sfp_chk #(
  parameter bit LARGE_BLOCK = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Read and write response timing and table words
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_rd(logic [7:0] a);
    ce_i && s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == a;
  endsequence
  property p_lat; s_rd(s_axi_araddr_i) |=> s_axi_rvalid_o; endproperty
  property p_rhold;
    s_axi_rvalid_o && !s_axi_rready_i |=> $stable(s_axi_rdata_o);
  endproperty
  property p_bhold;
    s_axi_bvalid_o && !s_axi_bready_i |=> $stable(s_axi_bresp_o);
  endproperty
  property p_w30; s_rd(8'h30) |=> s_axi_rdata_o == 32'hfffb20e5; endproperty
  property p_w34; s_rd(8'h34) |=> s_axi_rdata_o == 32'h1fffffff; endproperty
  property p_w38; s_rd(8'h38) |=> s_axi_rdata_o == 32'h6b08eb44; endproperty
  property p_w50;
    s_rd(8'h50) |=> s_axi_rdata_o ==
      (LARGE_BLOCK ? 32'hd812ff00 : 32'hff00d810);
  endproperty
  property p_w54; s_rd(8'h54) |=> s_axi_rdata_o[17:0] == 18'h14262; endproperty
  a_lat: assert property (p_lat) else $error("late read");
  a_rhold: assert property (p_rhold) else $error("rdata moved");
  a_bhold: assert property (p_bhold) else $error("bresp moved");
  a_w30: assert property (p_w30) else $error("word 30");
  a_w34: assert property (p_w34) else $error("word 34");
  a_w38: assert property (p_w38) else $error("word 38");
  a_w50: assert property (p_w50) else $error("word 50");
  a_w54: assert property (p_w54) else $error("word 54");
endmodule
bind sfp_rom sfp_chk #(.LARGE_BLOCK(LARGE_BLOCK)) chk_u (
  .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i));

// ### tb/sfp_host.sv
module sfp_host (
  input wire logic mclk_i,
  output logic awv_o,
  input wire logic awr_i,
  output logic wv_o,
  input wire logic wrdy_i,
  input wire logic [1:0] bresp_i,
  input wire logic bv_i,
  output logic br_o,
  output logic arv_o,
  input wire logic arr_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rv_i,
  output logic rr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // One access, ready held back lag cycles
  // ----------------------------------------------------------------
  initial {awv_o, wv_o, br_o, arv_o, rr_o} = '0;
  task automatic xfer(input logic wr, input int lag,
                      output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    awv_o <= wr;
    wv_o <= wr;
    arv_o <= !wr;
    do begin
      @(posedge mclk_i);
      if (awr_i) awv_o <= 1'b0;
      if (wrdy_i) wv_o <= 1'b0;
      if (arr_i) arv_o <= 1'b0;
    end while (awv_o && !awr_i || wv_o && !wrdy_i || arv_o && !arr_i);
    repeat (lag) @(posedge mclk_i);
    br_o <= wr;
    rr_o <= !wr;
    do @(posedge mclk_i);
    while (!(br_o && bv_i || rr_o && rv_i));
    d = rdata_i;
    r = wr ? bresp_i : rresp_i;
    br_o <= 1'b0;
    rr_o <= 1'b0;
  endtask
endmodule

// ### tb/sfp_basic_param_rom_test.sv
module sfp_basic_param_rom_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sel = 1'b0;
  logic ce = 1'b1;
  logic [3:0] ws = 4'hf;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [1:0] bresp, rresp;
  logic [31:0] rd_s, rd_l;
  int miscompares = 0;
  int cmp_count = 0;
  sfp_rom #(.LARGE_BLOCK(1'b0)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .s_axi_awaddr_i(addr),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(addr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd_s), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rr));
  sfp_rom #(.LARGE_BLOCK(1'b1)) dut_l (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .s_axi_awaddr_i(addr),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(),
    .s_axi_bresp_o(), .s_axi_bvalid_o(), .s_axi_bready_i(br),
    .s_axi_araddr_i(addr), .s_axi_arvalid_i(arv), .s_axi_arready_o(),
    .s_axi_rdata_o(rd_l), .s_axi_rresp_o(), .s_axi_rvalid_o(),
    .s_axi_rready_i(rr));
  sfp_host host_u (
    .mclk_i(mclk_i), .awv_o(awv), .awr_i(awr), .wv_o(wv), .wrdy_i(wrdy),
    .bresp_i(bresp), .bv_i(bv), .br_o(br), .arv_o(arv), .arr_i(arr),
    .rdata_i(sel ? rd_l : rd_s), .rresp_i(rresp), .rv_i(rv), .rr_o(rr));
  // ----------------------------------------------------------------
  // Checks and scenarios
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rk(input logic [7:0] a, input logic [31:0] e, input int lag);
    logic [31:0] d;
    logic [1:0] r;
    addr <= a;
    host_u.xfer(1'b0, lag, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, sfp_pkg::RESP_OKAY});
  endtask
  task automatic t_std;
    rk(8'h30, 32'hfffb20e5, 0);
    rk(8'h34, 32'h1fffffff, 0);
    rk(8'h38, 32'h6b08eb44, 0);
    rk(8'h3c, 32'hbb803b08, 0);
    rk(8'h40, 32'hfffffffe, 0);
    rk(8'h44, 32'hff00ffff, 0);
    rk(8'h48, 32'heb44ffff, 0);
    rk(8'h4c, 32'h520f200c, 0);
    rk(8'h50, 32'hff00d810, 0);
    rk(8'h54, 32'h00a94262, 0);
  endtask
  task automatic t_large;
    sel <= 1'b1;
    rk(8'h50, 32'hd812ff00, 0);
    rk(8'h54, 32'h4a014262, 2);
    sel <= 1'b0;
  endtask
  task automatic t_ro;
    logic [31:0] d;
    logic [1:0] r;
    addr <= 8'h30;
    host_u.xfer(1'b1, 2, d, r);
    chk({30'h0, r}, {30'h0, sfp_pkg::RESP_SLVERR});
    rk(8'h30, 32'hfffb20e5, 3);
    addr <= 8'h5c;
    host_u.xfer(1'b0, 0, d, r);
    chk({30'h0, r}, {30'h0, sfp_pkg::RESP_SLVERR});
    addr <= 8'h88;
    host_u.xfer(1'b0, 0, d, r);
    chk({16'h0, d[15:0]}, 32'h1030);
  endtask
  task automatic t_ctl;
    logic [31:0] d;
    logic [1:0] r;
    addr <= 8'h80;
    wd <= 32'h12345678;
    ws <= 4'h3;
    host_u.xfer(1'b1, 0, d, r);
    chk({30'h0, r}, {30'h0, sfp_pkg::RESP_OKAY});
    rk(8'h80, 32'h00005678, 1);
    ws <= 4'hf;
    sel <= 1'b1;
    addr <= 8'h84;
    host_u.xfer(1'b0, 0, d, r);
    chk({31'h0, d[16]}, 32'h00000001);
    sel <= 1'b0;
  endtask
  task automatic t_ce;
    logic [31:0] d;
    logic [1:0] r;
    addr <= 8'h4c;
    ce <= 1'b0;
    fork
      host_u.xfer(1'b0, 0, d, r);
      begin
        repeat (4) @(posedge mclk_i);
        chk({31'h0, rv}, 32'h00000000);
        ce <= 1'b1;
      end
    join
    chk(d, 32'h520f200c);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_std();
    t_large();
    t_ro();
    t_ctl();
    t_ce();
    conclude();
  end
  initial begin
    repeat (2000) @(posedge mclk_i);
    miscompares++;
    conclude();
  end
endmodule
